// >>> logic/msc_pkg.sv
package msc_pkg;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 32;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_STARTUP2  = 10'h086;
  localparam logic [9:0]  IDX_CTRL      = 10'h090;
  localparam logic [9:0]  IDX_REVERSE   = 10'h091;
  localparam logic [9:0]  IDX_STATUS    = 10'h092;
  localparam logic [31:0] RST_STARTUP2  = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL      = 32'h0000_0000;
  localparam logic [31:0] RST_REVERSE   = 32'h0000_0000;
  // startup2 field positions
  localparam int unsigned POS_PARITY    = 31;
  localparam int unsigned POS_CAP_LO    = 27;
  localparam int unsigned POS_LIN_LO    = 23;
  localparam int unsigned POS_QUAD_LO   = 19;
  localparam int unsigned POS_AUTO      = 18;
  localparam int unsigned POS_THR_LO    = 13;
  // control register fields
  localparam int unsigned POS_LIM_SRC   = 3;
  localparam int unsigned POS_REV_SEL   = 0;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_0009;
  // reverse settings fields
  localparam int unsigned POS_RCAP_LO   = 8;
  localparam int unsigned POS_RLIN_LO   = 4;
  localparam int unsigned POS_RQUAD_LO  = 0;
  localparam logic [31:0] REV_MASK      = 32'h0000_0FFF;
  // threshold coding, tenths of a percent
  localparam logic [4:0]  THR_FINE_LAST = 5'h13;
  localparam logic [9:0]  THR_FINE_STEP = 10'h00A;
  localparam logic [9:0]  THR_FINE_TOP  = 10'h0C8;
  localparam logic [9:0]  THR_WIDE_STEP = 10'h019;
endpackage : msc_pkg

// >>> logic/msc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface msc_cfg_if;
  logic [3:0]  cap_code;
  logic [3:0]  lin_code;
  logic [3:0]  quad_code;
  logic [4:0]  thr_code;
  logic [13:0] cap_ma;
  logic [19:0] lin_centi;
  logic [19:0] quad_centi;
  logic [9:0]  thr_tenths;
  modport src (output cap_code, lin_code, quad_code, thr_code,
               input cap_ma, lin_centi, quad_centi, thr_tenths);
  modport dec (input cap_code, lin_code, quad_code, thr_code,
               output cap_ma, lin_centi, quad_centi, thr_tenths);
endinterface : msc_cfg_if
`default_nettype wire

// >>> logic/msc_decode.sv
`timescale 1ns/1ps
`default_nettype none
module msc_decode
  import msc_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  msc_cfg_if.dec    cfg
);
  logic [13:0] next_cap_ma;
  logic [19:0] next_lin_centi;
  logic [19:0] next_quad_centi;
  logic [9:0]  next_thr_tenths;

  // open-loop current cap in mA
  always_comb begin
    case (cfg.cap_code)
      4'h0: next_cap_ma = 14'h007D;
      4'h1: next_cap_ma = 14'h00FA;
      4'h2: next_cap_ma = 14'h01F4;
      4'h3: next_cap_ma = 14'h03E8;
      4'h4: next_cap_ma = 14'h05DC;
      4'h5: next_cap_ma = 14'h07D0;
      4'h6: next_cap_ma = 14'h09C4;
      4'h7: next_cap_ma = 14'h0BB8;
      4'h8: next_cap_ma = 14'h0DAC;
      4'h9: next_cap_ma = 14'h0FA0;
      4'hA: next_cap_ma = 14'h1194;
      4'hB: next_cap_ma = 14'h1388;
      4'hC: next_cap_ma = 14'h157C;
      4'hD: next_cap_ma = 14'h1770;
      4'hE: next_cap_ma = 14'h1B58;
      default: next_cap_ma = 14'h1F40;
    endcase
  end

  function automatic logic [19:0] accel_centi(input logic [3:0] code);
    case (code)
      4'h0: accel_centi = 20'h00001;
      4'h1: accel_centi = 20'h00005;
      4'h2: accel_centi = 20'h00064;
      4'h3: accel_centi = 20'h000FA;
      4'h4: accel_centi = 20'h001F4;
      4'h5: accel_centi = 20'h003E8;
      4'h6: accel_centi = 20'h009C4;
      4'h7: accel_centi = 20'h01388;
      4'h8: accel_centi = 20'h01D4C;
      4'h9: accel_centi = 20'h02710;
      4'hA: accel_centi = 20'h061A8;
      4'hB: accel_centi = 20'h0C350;
      4'hC: accel_centi = 20'h124F8;
      4'hD: accel_centi = 20'h186A0;
      4'hE: accel_centi = 20'h7A120;
      default: accel_centi = 20'hF4240;
    endcase
  endfunction

  // linear and quadratic share a table except quadratic code 0 is zero
  assign next_lin_centi  = accel_centi(cfg.lin_code);
  assign next_quad_centi = (cfg.quad_code == 4'h0) ? 20'h00000
                                                   : accel_centi(cfg.quad_code);
  // 1 % steps to 20 %, then 2.5 % steps to 50 %
  assign next_thr_tenths = (cfg.thr_code <= THR_FINE_LAST)
    ? 10'((10'(cfg.thr_code) + 10'h001) * THR_FINE_STEP)
    : 10'(THR_FINE_TOP + 10'(cfg.thr_code - THR_FINE_LAST) * THR_WIDE_STEP);

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cfg.cap_ma     <= 14'h0000;
      cfg.lin_centi  <= 20'h00000;
      cfg.quad_centi <= 20'h00000;
      cfg.thr_tenths <= 10'h000;
    end else begin
      cfg.cap_ma     <= next_cap_ma;
      cfg.lin_centi  <= next_lin_centi;
      cfg.quad_centi <= next_quad_centi;
      cfg.thr_tenths <= next_thr_tenths;
    end
  end
endmodule // msc_decode
`default_nettype wire

// >>> logic/msc_config_regs.sv
// Operation
// - startup config register at index 86h, 32 bits, all read/write, resets to zero
// - bits 30..27 select open-loop current cap, 0.125 A up to 8.0 A
// - bits 26..23 select linear open-loop acceleration, up to 10000 Hz/s
// - bits 22..19 select quadratic acceleration, code 0 zero, code Fh 10000
// - bit 18 set gives automatic handoff, clear uses programmed threshold
// - bits 17..13 handoff threshold, 1 % steps to 20 %, then 2.5 % to 50 %
// - open-loop cap applies only when limit source bit is zero, else closed-loop cap
// - reverse drive takes current and accelerations from forward or reverse settings
`timescale 1ns/1ps
`default_nettype none
module msc_config_regs
  import msc_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [DATA_W-1:0] pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  input  wire logic              reverse_drive_in,
  output logic [DATA_W-1:0]      prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [3:0]             open_loop_current_cap_out,
  output logic                   use_closed_loop_cap_out,
  output logic [13:0]            open_loop_current_ma_out,
  output logic [3:0]             open_loop_accel_linear_out,
  output logic [19:0]            accel_linear_centi_out,
  output logic [3:0]             open_loop_accel_quadratic_out,
  output logic [19:0]            accel_quadratic_centi_out,
  output logic                   auto_handoff_out,
  output logic [4:0]             loop_transfer_speed_threshold_out,
  output logic [9:0]             threshold_tenths_pct_out,
  output logic                   reverse_params_active_out
);
  logic [31:0] motor_startup_config_2;
  logic [31:0] drive_control;
  logic [31:0] reverse_settings;
  msc_cfg_if   cfg ();

  // apb decode
  wire         setup_phase  = psel_in & ~penable_in;
  wire         access_done  = psel_in & penable_in & pready_out;
  wire  [9:0]  word_index   = paddr_in[ADDR_W-1:2];
  wire         aligned      = (paddr_in[1:0] == 2'b00);
  wire         hit_startup  = aligned & (word_index == IDX_STARTUP2);
  wire         hit_ctrl     = aligned & (word_index == IDX_CTRL);
  wire         hit_reverse  = aligned & (word_index == IDX_REVERSE);
  wire         hit_status   = aligned & (word_index == IDX_STATUS);
  wire         mapped       = hit_startup | hit_ctrl | hit_reverse | hit_status;
  wire         bad_write    = pwrite_in & hit_status;
  wire         wr_ok        = access_done & pwrite_in & ~pslverr_out;
  wire  [31:0] byte_mask;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign byte_mask[lane*8 +: 8] = {8{pstrb_in[lane]}};
    end
  endgenerate

  wire  [31:0] merged_startup = (motor_startup_config_2 & ~byte_mask)
                              | (pwdata_in & byte_mask);
  wire  [31:0] merged_ctrl    = ((drive_control & ~byte_mask)
                              | (pwdata_in & byte_mask)) & CTRL_MASK;
  wire  [31:0] merged_reverse = ((reverse_settings & ~byte_mask)
                              | (pwdata_in & byte_mask)) & REV_MASK;

  // field views
  wire         limit_source  = drive_control[POS_LIM_SRC];
  wire         rev_select    = drive_control[POS_REV_SEL];
  wire         use_reverse   = reverse_drive_in & rev_select;
  wire  [3:0]  fwd_cap       = motor_startup_config_2[POS_CAP_LO +: 4];
  wire  [3:0]  fwd_lin       = motor_startup_config_2[POS_LIN_LO +: 4];
  wire  [3:0]  fwd_quad      = motor_startup_config_2[POS_QUAD_LO +: 4];
  wire  [3:0]  next_cap      = use_reverse ? reverse_settings[POS_RCAP_LO +: 4] : fwd_cap;
  wire  [3:0]  next_lin      = use_reverse ? reverse_settings[POS_RLIN_LO +: 4] : fwd_lin;
  wire  [3:0]  next_quad     = use_reverse ? reverse_settings[POS_RQUAD_LO +: 4] : fwd_quad;
  wire         next_auto     = motor_startup_config_2[POS_AUTO];
  wire  [4:0]  next_thr      = motor_startup_config_2[POS_THR_LO +: 5];

  wire  [31:0] status_word   = {12'h000, use_reverse, limit_source, next_auto, next_thr,
                                next_quad, next_lin, next_cap};
  wire  [31:0] next_rdata    = hit_startup ? motor_startup_config_2
                             : hit_ctrl    ? drive_control
                             : hit_reverse ? reverse_settings
                             : hit_status  ? status_word
                             : 32'h0000_0000;

  // selected codes to the value decoder
  assign cfg.cap_code  = open_loop_current_cap_out;
  assign cfg.lin_code  = open_loop_accel_linear_out;
  assign cfg.quad_code = open_loop_accel_quadratic_out;
  assign cfg.thr_code  = loop_transfer_speed_threshold_out;

  msc_decode u_decode (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .cfg        (cfg)
  );

  // one wait-free access phase per transfer
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup_phase;
      pslverr_out <= setup_phase & (~mapped | bad_write);
      prdata_out  <= (setup_phase & ~pwrite_in) ? next_rdata : 32'h0000_0000;
    end
  end

  // parity bit is kept as an ordinary bit
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      motor_startup_config_2 <= RST_STARTUP2;
    end else if (wr_ok & hit_startup) begin
      motor_startup_config_2 <= merged_startup;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      drive_control <= RST_CTRL;
    end else if (wr_ok & hit_ctrl) begin
      drive_control <= merged_ctrl;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      reverse_settings <= RST_REVERSE;
    end else if (wr_ok & hit_reverse) begin
      reverse_settings <= merged_reverse;
    end
  end

  // effective startup settings
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      open_loop_current_cap_out <= 4'h0;
    end else begin
      open_loop_current_cap_out <= next_cap;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      use_closed_loop_cap_out <= 1'b0;
    end else begin
      use_closed_loop_cap_out <= limit_source;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      open_loop_accel_linear_out <= 4'h0;
    end else begin
      open_loop_accel_linear_out <= next_lin;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      open_loop_accel_quadratic_out <= 4'h0;
    end else begin
      open_loop_accel_quadratic_out <= next_quad;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      auto_handoff_out <= 1'b0;
    end else begin
      auto_handoff_out <= next_auto;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      loop_transfer_speed_threshold_out <= 5'h00;
    end else begin
      loop_transfer_speed_threshold_out <= next_thr;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      reverse_params_active_out <= 1'b0;
    end else begin
      reverse_params_active_out <= use_reverse;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      open_loop_current_ma_out <= 14'h0000;
    end else begin
      // cap value is meaningless while the closed-loop cap governs
      open_loop_current_ma_out <= use_closed_loop_cap_out ? 14'h0000 : cfg.cap_ma;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      accel_linear_centi_out <= 20'h00000;
    end else begin
      accel_linear_centi_out <= cfg.lin_centi;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      accel_quadratic_centi_out <= 20'h00000;
    end else begin
      accel_quadratic_centi_out <= cfg.quad_centi;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      threshold_tenths_pct_out <= 10'h000;
    end else begin
      // threshold value only matters without auto handoff
      threshold_tenths_pct_out <= auto_handoff_out ? 10'h000 : cfg.thr_tenths;
    end
  end
endmodule // msc_config_regs
`default_nettype wire

// >>> dv/msc_config_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module msc_config_regs_assertions
  import msc_pkg::*;
(
  input wire logic              sys_clk_in,
  input wire logic              reset_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  input wire logic [3:0]        pstrb_in,
  input wire logic              reverse_drive_in,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic [3:0]        open_loop_current_cap_out,
  input wire logic              use_closed_loop_cap_out,
  input wire logic [13:0]       open_loop_current_ma_out,
  input wire logic              auto_handoff_out,
  input wire logic [4:0]        loop_transfer_speed_threshold_out,
  input wire logic [9:0]        threshold_tenths_pct_out,
  input wire logic              reverse_params_active_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_wr_startup;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h218
      && pstrb_in == 4'hF && !pslverr_out;
  endsequence
  sequence s_wr_fwd;
    (s_wr_startup ##0 !reverse_drive_in) ##1 !reverse_drive_in;
  endsequence
  property p_ready_after_setup;
    psel_in && !penable_in |=> pready_out;
  endproperty
  property p_ready_only_access;
    pready_out |-> $past(psel_in && !penable_in);
  endproperty
  property p_cap_code;
    s_wr_fwd |=> open_loop_current_cap_out == $past(pwdata_in[30:27], 2);
  endproperty
  property p_cap_top;
    (open_loop_current_cap_out == 4'hF && !use_closed_loop_cap_out) [*2]
      |=> open_loop_current_ma_out == 14'h1F40;
  endproperty
  property p_auto_bit;
    s_wr_startup |=> ##1 auto_handoff_out == $past(pwdata_in[18], 2);
  endproperty
  property p_thr_code;
    s_wr_startup |-> ##2 loop_transfer_speed_threshold_out == $past(pwdata_in[17:13], 2);
  endproperty
  property p_auto_no_thr;
    auto_handoff_out |=> threshold_tenths_pct_out == 10'h000;
  endproperty
  property p_closed_cap;
    use_closed_loop_cap_out |=> open_loop_current_ma_out == 14'h0000;
  endproperty
  property p_rev_needs_drive;
    !$past(reverse_drive_in) |-> !reverse_params_active_out;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
  a_ready_only_access: assert property (p_ready_only_access) else $error("stray ready");
  a_cap_code: assert property (p_cap_code) else $error("cap code");
  a_cap_top: assert property (p_cap_top) else $error("cap top");
  a_auto_bit: assert property (p_auto_bit) else $error("auto bit");
  a_thr_code: assert property (p_thr_code) else $error("thr code");
  a_auto_no_thr: assert property (p_auto_no_thr) else $error("thr gated");
  a_closed_cap: assert property (p_closed_cap) else $error("closed cap");
  a_rev_needs_drive: assert property (p_rev_needs_drive) else $error("rev");
endmodule // msc_config_regs_assertions
bind msc_config_regs msc_config_regs_assertions u_chk (.sys_clk_in, .reset_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .reverse_drive_in, .pready_out,
  .pslverr_out, .open_loop_current_cap_out, .use_closed_loop_cap_out, .open_loop_current_ma_out,
  .auto_handoff_out, .loop_transfer_speed_threshold_out, .threshold_tenths_pct_out,
  .reverse_params_active_out);
`default_nettype wire

// >>> dv/msc_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module msc_config_regs_tb;
  import msc_pkg::*;
  logic        sys_clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic        pwrite_in = 1'b0, reverse_drive_in = 1'b0, err;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, rd;
  logic [3:0]  pstrb_in = 4'hF;
  wire logic [31:0] prdata_out;
  wire logic        pready_out, pslverr_out, use_closed_loop_cap_out, auto_handoff_out;
  wire logic        reverse_params_active_out;
  wire logic [3:0]  open_loop_current_cap_out, open_loop_accel_linear_out;
  wire logic [3:0]  open_loop_accel_quadratic_out;
  wire logic [13:0] open_loop_current_ma_out;
  wire logic [19:0] accel_linear_centi_out, accel_quadratic_centi_out;
  wire logic [4:0]  loop_transfer_speed_threshold_out;
  wire logic [9:0]  threshold_tenths_pct_out;
  int n_errors = 0, checked = 0;
  int unsigned cap_t[16] = '{125, 250, 500, 1000, 1500, 2000, 2500, 3000, 3500, 4000, 4500,
                             5000, 5500, 6000, 7000, 8000};
  int unsigned acc_t[16] = '{1, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 25000,
                             50000, 75000, 100000, 500000, 1000000};
  msc_config_regs dut (.sys_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .reverse_drive_in, .prdata_out, .pready_out, .pslverr_out,
    .open_loop_current_cap_out, .use_closed_loop_cap_out, .open_loop_current_ma_out,
    .open_loop_accel_linear_out, .accel_linear_centi_out, .open_loop_accel_quadratic_out,
    .accel_quadratic_centi_out, .auto_handoff_out, .loop_transfer_speed_threshold_out,
    .threshold_tenths_pct_out, .reverse_params_active_out);
  always #4 sys_clk_in = ~sys_clk_in;
  task automatic final_report;
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 8);
    if (pready_out !== 1'b1) begin
      n_errors++;
      final_report();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp, "read data");
    chk({31'h0, err}, {31'h0, e}, "slave error");
  endtask
  task automatic settle;
    repeat (4) @(negedge sys_clk_in);
  endtask
  task automatic t_reset_vals;
    rdchk(12'h218, 32'h0, 1'b0);
    rdchk(12'h240, 32'h0, 1'b0);
    rdchk(12'h244, 32'h0, 1'b0);
    rdchk(12'h248, 32'h0, 1'b0);
  endtask
  task automatic t_rw_bits;
    wr(12'h218, 32'hFFFF_FFFF);
    rdchk(12'h218, 32'hFFFF_FFFF, 1'b0);
    apb(1'b1, 12'h218, 32'h0, 4'h1);
    rdchk(12'h218, 32'hFFFF_FF00, 1'b0);
    wr(12'h218, 32'h8000_0000);
    rdchk(12'h218, 32'h8000_0000, 1'b0);
    wr(12'h240, 32'hFFFF_FFFF);
    rdchk(12'h240, 32'h0000_0009, 1'b0);
    wr(12'h240, 32'h0);
  endtask
  task automatic t_codes;
    for (int c = 0; c < 16; c++) begin
      wr(12'h218, {1'b0, c[3:0], c[3:0], c[3:0], 19'h0});
      settle();
      chk(open_loop_current_ma_out, cap_t[c], "cap mA");
      chk(accel_linear_centi_out, acc_t[c], "linear");
      chk(accel_quadratic_centi_out, (c == 0) ? 0 : acc_t[c], "quadratic");
    end
  endtask
  task automatic t_thr;
    for (int c = 0; c < 32; c++) begin
      wr(12'h218, {14'h0, c[4:0], 13'h0});
      settle();
      chk(threshold_tenths_pct_out, (c < 20) ? (c + 1) * 10 : 200 + (c - 19) * 25, "thr");
    end
    wr(12'h218, 32'h0007_E000);
    settle();
    chk(auto_handoff_out, 1'b1, "auto");
    chk(threshold_tenths_pct_out, 32'h0, "thr gated");
  endtask
  task automatic t_limit;
    wr(12'h218, 32'h7800_0000);
    wr(12'h240, 32'h8);
    settle();
    chk(open_loop_current_ma_out, 32'h0, "closed cap");
    chk({31'h0, use_closed_loop_cap_out}, 32'h1, "limit source on");
    wr(12'h240, 32'h0);
    settle();
    chk(open_loop_current_ma_out, 32'd8000, "open cap");
    chk({31'h0, use_closed_loop_cap_out}, 32'h0, "limit source off");
  endtask
  task automatic t_rev;
    wr(12'h218, 32'h11A0_0000);
    wr(12'h244, 32'hFFFF_FABC);
    wr(12'h240, 32'h1);
    @(posedge sys_clk_in);
    reverse_drive_in <= 1'b1;
    settle();
    chk({open_loop_current_cap_out, open_loop_accel_linear_out,
         open_loop_accel_quadratic_out}, 32'hABC, "rev codes");
    chk({31'h0, reverse_params_active_out}, 32'h1, "rev active");
    rdchk(12'h248, 32'h0008_0CBA, 1'b0);
    wr(12'h240, 32'h0);
    settle();
    chk({open_loop_current_cap_out, open_loop_accel_linear_out,
         open_loop_accel_quadratic_out}, 32'h234, "fwd codes");
    chk({31'h0, reverse_params_active_out}, 32'h0, "rev inactive");
    @(posedge sys_clk_in);
    reverse_drive_in <= 1'b0;
  endtask
  task automatic t_errors;
    wr(12'h300, 32'h1);
    chk({31'h0, err}, 32'h1, "unmapped write");
    rdchk(12'h300, 32'h0, 1'b1);
    wr(12'h219, 32'h0);
    chk({31'h0, err}, 32'h1, "misaligned");
    rdchk(12'h218, 32'h11A0_0000, 1'b0);
    wr(12'h248, 32'h0);
    chk({31'h0, err}, 32'h1, "status write");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    t_reset_vals();
    t_rw_bits();
    t_codes();
    t_thr();
    t_limit();
    t_rev();
    t_errors();
    final_report();
  end
endmodule // msc_config_regs_tb
`default_nettype wire
